// file: pkg/sfspi_params.svh
// opcodes, layouts and timing counts of the serial flash pin front end
// assumes inclusion by bare name from package and design files
`ifndef SFSPI_PARAMS_SVH
`define SFSPI_PARAMS_SVH
`define SFSPI_OP_READ      8'h11
`define SFSPI_OP_DREAD     8'h12
`define SFSPI_OP_PROG      8'h13
`define SFSPI_OP_DPROG     8'h14
`define SFSPI_OP_ERASE4K   8'h15
`define SFSPI_OP_ERASE32K  8'h16
`define SFSPI_OP_ERASE64K  8'h17
`define SFSPI_OP_CHIP      8'h18
`define SFSPI_OP_PROTECT   8'h19
`define SFSPI_OP_UNPROTECT 8'h1a
`define SFSPI_OP_GPROTECT  8'h1b
`define SFSPI_OP_GUNPROT   8'h1c
`define SFSPI_OP_LOCK      8'h1d
`define SFSPI_OP_OTP_PROG  8'h1e
`define SFSPI_OP_OTP_READ  8'h1f
`define SFSPI_OP_STATUS    8'h20
`define SFSPI_PAGE_BYTES   9'h100
`define SFSPI_OTP_BYTES    24'h000080
`define SFSPI_SECTORS      16
`define SFSPI_STAT_BUSY    0
`define SFSPI_STAT_FAIL    1
`define SFSPI_PIN_IDLE     6'h2c
`define SFSPI_HALF_LAST    4'h7
`define SFSPI_ADDR_BYTES   2'h3
`endif

// file: pkg/sfspi_pkg.sv
// types shared by both ends of the serial flash link
// assumes sfspi_params.svh on the include path
`include "sfspi_params.svh"
package sfspi_pkg;
  typedef enum logic [3:0] {OPK_NONE, OPK_PROG, OPK_ERASE4K, OPK_ERASE32K, OPK_ERASE64K,
                            OPK_CHIP, OPK_OTP_PROG} sfspi_op_e;
  typedef enum logic [2:0] {DS_IDLE, DS_CMD, DS_ADDR, DS_WDATA, DS_RDATA, DS_ARMED, DS_SKIP} sfspi_dst_e;
  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TAIL, HS_HOLD} sfspi_hst_e;
endpackage : sfspi_pkg

// file: pkg/sfspi_link_if.sv
// pin bundle between host controller and flash front end
// resolves the two shared data lines and the pulled-up inputs
`timescale 1ns/1ps
interface sfspi_link_if;
  logic cs_n;
  logic sck;
  logic host_sio_o;
  logic host_sio_oe;
  logic dev_sio_o;
  logic dev_sio_oe;
  logic host_soi_o;
  logic host_soi_oe;
  logic dev_soi_o;
  logic dev_soi_oe;
  logic hold_n_o;
  logic hold_oe;
  logic wp_n_o;
  logic wp_oe;
  logic serial_in_dual_line;
  logic serial_out_dual_line;
  logic hold_n;
  logic wp_n;
  // undriven lines read high, as the pull-ups make them
  assign serial_in_dual_line  = dev_sio_oe ? dev_sio_o : (host_sio_oe ? host_sio_o : 1'b1);
  assign serial_out_dual_line = dev_soi_oe ? dev_soi_o : (host_soi_oe ? host_soi_o : 1'b1);
  assign hold_n = hold_oe ? hold_n_o : 1'b1;
  assign wp_n   = wp_oe ? wp_n_o : 1'b1;
  modport dev (input cs_n, sck, serial_in_dual_line, serial_out_dual_line, hold_n, wp_n,
               output dev_sio_o, dev_sio_oe, dev_soi_o, dev_soi_oe);
  modport host (input serial_in_dual_line, serial_out_dual_line,
                output cs_n, sck, host_sio_o, host_sio_oe, host_soi_o, host_soi_oe,
                hold_n_o, hold_oe, wp_n_o, wp_oe);
endinterface : sfspi_link_if

// file: rtl/sfspi_host_end.sv
// host controller end: makes the serial clock, frames one command per start
// assumes a user that holds wr_data valid until wr_take
`timescale 1ns/1ps
`include "sfspi_params.svh"
module sfspi_host_end
  import sfspi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [23:0] cmd_addr,
  input  wire logic        addr_en,
  input  wire logic [8:0]  wr_len,
  input  wire logic [8:0]  rd_len,
  input  wire logic        dual_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        hold_req,
  input  wire logic        wp_req,
  output logic             busy,
  output logic             wr_take,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  sfspi_link_if.host       link
);
  logic [1:0]  in_m;
  logic [1:0]  in_s;
  sfspi_hst_e  st;
  logic [3:0]  cnt;
  logic [7:0]  sh;
  logic [7:0]  rsh;
  logic [23:0] abuf;
  logic [2:0]  bitcnt;
  logic [1:0]  hdr;
  logic [8:0]  dleft;
  logic        in_data;
  logic        rd_frame;
  logic        dual;

  wire       so_s     = in_s[1];
  wire       sio_s    = in_s[0];
  wire       half     = cnt == `SFSPI_HALF_LAST;
  wire       two      = in_data & dual;
  wire [2:0] next_bit = two ? bitcnt + 3'h2 : bitcnt + 3'h1;
  wire [7:0] next_rsh = two ? {rsh[5:0], so_s, sio_s} : {rsh[6:0], so_s};
  wire       rise     = (st == HS_LOW) & half & ~hold_req;
  wire       fall     = (st == HS_HIGH) & half;
  wire       framed   = (st == HS_LOW) | (st == HS_HIGH) | (st == HS_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_m <= 2'h3;
      in_s <= 2'h3;
    end else if (ce) begin
      in_m <= {link.serial_out_dual_line, link.serial_in_dual_line};
      in_s <= in_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= HS_IDLE;
      cnt <= 4'h0;
      busy <= 1'b0;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      sh <= 8'h00;
      rsh <= 8'h00;
      abuf <= 24'h000000;
      bitcnt <= 3'h0;
      hdr <= 2'h0;
      dleft <= 9'h000;
      in_data <= 1'b0;
      rd_frame <= 1'b0;
      dual <= 1'b0;
    end else if (ce) begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      cnt <= half ? 4'h0 : cnt + 4'h1;
      case (st)
        HS_IDLE: begin
          cnt <= 4'h0;
          if (start) begin
            link.cs_n <= 1'b0;
            busy <= 1'b1;
            sh <= cmd_op;
            abuf <= cmd_addr;
            hdr <= addr_en ? `SFSPI_ADDR_BYTES : 2'h0;
            dleft <= (rd_len != 9'h000) ? rd_len : wr_len;
            rd_frame <= rd_len != 9'h000;
            dual <= dual_en;
            in_data <= 1'b0;
            bitcnt <= 3'h0;
            st <= HS_LEAD;
          end
        end
        HS_LEAD: if (half) st <= HS_LOW;
        HS_LOW: begin
          if (half & hold_req) begin
            st <= HS_HOLD;
          end else if (rise) begin
            link.sck <= 1'b1;
            bitcnt <= next_bit;
            if (in_data & rd_frame) rsh <= next_rsh;
            if (in_data & (next_bit == 3'h0)) begin
              dleft <= dleft - 9'h001;
              rd_valid <= rd_frame;
              rd_data <= next_rsh;
            end
            st <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (fall) begin
            link.sck <= 1'b0;
            st <= HS_LOW;
            if (bitcnt != 3'h0) begin
              sh <= two ? {sh[5:0], 2'h0} : {sh[6:0], 1'b0};
            end else if (hdr != 2'h0) begin
              sh <= abuf[23:16];
              abuf <= {abuf[15:0], 8'h00};
              hdr <= hdr - 2'h1;
            end else if (dleft != 9'h000) begin
              in_data <= 1'b1;
              if (!rd_frame) begin
                sh <= wr_data;
                wr_take <= 1'b1;
              end
            end else begin
              st <= HS_TAIL;
            end
          end
        end
        HS_HOLD: begin
          cnt <= 4'h0;
          if (!hold_req) st <= HS_LOW;
        end
        HS_TAIL: begin
          if (half) begin
            link.cs_n <= 1'b1;
            busy <= 1'b0;
            st <= HS_IDLE;
          end
        end
        default: st <= HS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link.host_sio_o <= 1'b1;
      link.host_sio_oe <= 1'b0;
      link.host_soi_o <= 1'b1;
      link.host_soi_oe <= 1'b0;
      link.hold_n_o <= 1'b0;
      link.hold_oe <= 1'b0;
      link.wp_n_o <= 1'b0;
      link.wp_oe <= 1'b0;
    end else if (ce) begin
      link.host_sio_o <= two ? sh[6] : sh[7];
      link.host_soi_o <= sh[7];
      // release input line for dual read
      link.host_sio_oe <= framed & ~(in_data & rd_frame & dual);
      // drive both lines in dual write
      link.host_soi_oe <= framed & in_data & ~rd_frame & dual;
      link.hold_n_o <= 1'b0;
      link.hold_oe <= st == HS_HOLD;
      link.wp_n_o <= 1'b0;
      link.wp_oe <= wp_req;
    end
  end
endmodule : sfspi_host_end

// file: rtl/sfspi_dev_end.sv
// flash device end: pin sampling, command/address/data shifting, protection
// assumes a back end that answers rd_addr one cycle later on rd_data
`timescale 1ns/1ps
`include "sfspi_params.svh"
// Functional notes
// - deselect gives standby, output floats
// - ignore input lines while deselected
// - operations start and end on select edges
// - standby waits for self-timed cycle end
// - capture input bits on clock rise
// - change output bits on clock fall
// - dual read drives two lines per fall
// - dual program captures two bits per rise
// - hold pauses, ignores clock, floats output
// - host holds only selected, clock low
// - hold leaves self-timed cycles running
// - write protect locks protection, pulled up
// - hold input pulled up, floating means none
// - clock modes 0 and 3 only
// - program takes 1 to 256 bytes
// - 4K, 32K, 64K and chip erase
// - 16 sectors, individual and global protection
// - locked sectors refuse program and erase
// - 128-byte one-time programmable register
// - failed or refused operations reported
module sfspi_dev_end
  import sfspi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [7:0]  rd_data,
  input  wire logic        mem_busy,
  input  wire logic        mem_fail,
  output logic             mem_start,
  output sfspi_op_e        mem_op,
  output logic [23:0]      mem_addr,
  output logic [8:0]       mem_len,
  output logic [7:0]       mem_wdata,
  output logic             mem_wvalid,
  output logic [23:0]      rd_addr,
  output logic             rd_otp,
  output logic             standby,
  output logic             wp_lock,
  sfspi_link_if.dev        link
);
  logic [5:0]              pin_m;
  logic [5:0]              pin_s;
  logic                    sck_q;
  logic                    cs_q;
  sfspi_dst_e              st;
  logic [7:0]              opc;
  logic [7:0]              sh;
  logic [2:0]              bitcnt;
  logic [1:0]              acnt;
  logic [23:0]             addr;
  logic [8:0]              wr_cnt;
  logic                    rd_on;
  logic                    fail;
  logic                    otp_used;
  logic [`SFSPI_SECTORS-1:0] prot;
  logic [`SFSPI_SECTORS-1:0] lock;

  function automatic logic sfspi_has_addr(input logic [7:0] c);
    return (c == `SFSPI_OP_READ) | (c == `SFSPI_OP_DREAD) | (c == `SFSPI_OP_PROG) |
           (c == `SFSPI_OP_DPROG) | (c == `SFSPI_OP_ERASE4K) | (c == `SFSPI_OP_ERASE32K) |
           (c == `SFSPI_OP_ERASE64K) | (c == `SFSPI_OP_PROTECT) | (c == `SFSPI_OP_UNPROTECT) |
           (c == `SFSPI_OP_LOCK) | (c == `SFSPI_OP_OTP_PROG) | (c == `SFSPI_OP_OTP_READ);
  endfunction : sfspi_has_addr

  ////////////////////////////////////////////////////////////////////////////
  // pin decode; hold and write protect idle high thanks to the pull-ups
  wire cs_n_s   = pin_s[5];
  wire sck_s    = pin_s[4];
  wire hold_n_s = pin_s[3];
  wire wp_n_s   = pin_s[2];
  wire sio_s    = pin_s[1];
  wire soi_s    = pin_s[0];
  // edges seen only selected, not held
  wire active      = ~cs_n_s & hold_n_s;
  // edge based, so either idle level works
  wire rise        = active & sck_s & ~sck_q;
  wire fall        = active & ~sck_s & sck_q;
  wire frame_start = ~cs_n_s & cs_q;
  wire frame_end   = cs_n_s & ~cs_q;

  wire dual_rd   = opc == `SFSPI_OP_DREAD;
  wire dual_wr   = opc == `SFSPI_OP_DPROG;
  wire is_read   = (opc == `SFSPI_OP_READ) | dual_rd | (opc == `SFSPI_OP_OTP_READ);
  wire is_prog   = (opc == `SFSPI_OP_PROG) | dual_wr | (opc == `SFSPI_OP_OTP_PROG);
  wire in_dual   = (st == DS_WDATA) & dual_wr;
  wire two       = in_dual | ((st == DS_RDATA) & dual_rd);
  // two bits per rise in dual program
  wire [7:0] next_sh  = in_dual ? {sh[5:0], soi_s, sio_s} : {sh[6:0], sio_s};
  wire [2:0] next_bit = two ? bitcnt + 3'h2 : bitcnt + 3'h1;
  wire       byte_done = rise & (next_bit == 3'h0);
  wire       no_addr   = (next_sh == `SFSPI_OP_CHIP) | (next_sh == `SFSPI_OP_GPROTECT) |
                         (next_sh == `SFSPI_OP_GUNPROT);

  wire [7:0] stat_byte = {6'h00, fail, mem_busy};
  wire [7:0] src       = (opc == `SFSPI_OP_STATUS) ? stat_byte : rd_data;
  wire [7:0] out_byte  = (bitcnt == 3'h0) ? src : sh;

  ////////////////////////////////////////////////////////////////////////////
  // commit decode at the end of a frame
  wire [3:0] sector    = addr[19:16];
  wire       guarded   = prot[sector] | lock[sector];
  wire       arr_op    = is_prog | (opc == `SFSPI_OP_ERASE4K) | (opc == `SFSPI_OP_ERASE32K) |
                         (opc == `SFSPI_OP_ERASE64K) | (opc == `SFSPI_OP_CHIP);
  wire       otp_bad   = otp_used | (addr >= `SFSPI_OTP_BYTES);
  // locked or protected sectors refuse changes
  wire       blocked   = (opc == `SFSPI_OP_CHIP) ? |(prot | lock) :
                         (opc == `SFSPI_OP_OTP_PROG) ? otp_bad : guarded;
  wire       cmd_ready = (st == DS_ARMED) | ((st == DS_WDATA) & (wr_cnt != 9'h000));
  wire       go        = frame_end & cmd_ready & ~mem_busy;
  wire       launch    = go & arr_op & ~blocked;
  wire       unprot    = (opc == `SFSPI_OP_UNPROTECT) | (opc == `SFSPI_OP_GUNPROT);
  wire       hw_refuse = go & unprot & ~wp_n_s;
  wire       refuse    = (go & arr_op & blocked) | hw_refuse;
  wire       set_one   = go & ((opc == `SFSPI_OP_PROTECT) | (opc == `SFSPI_OP_LOCK));
  wire       set_all   = go & (opc == `SFSPI_OP_GPROTECT);
  wire       clr_one   = go & wp_n_s & (opc == `SFSPI_OP_UNPROTECT);
  wire       clr_all   = go & wp_n_s & (opc == `SFSPI_OP_GUNPROT);
  // bytes past a page are dropped
  wire       wr_take   = byte_done & (st == DS_WDATA) & (wr_cnt < `SFSPI_PAGE_BYTES);
  // operation kind and erase granularity passed to the back end
  wire sfspi_op_e kind = (opc == `SFSPI_OP_ERASE4K) ? OPK_ERASE4K :
                         (opc == `SFSPI_OP_ERASE32K) ? OPK_ERASE32K :
                         (opc == `SFSPI_OP_ERASE64K) ? OPK_ERASE64K :
                         (opc == `SFSPI_OP_CHIP) ? OPK_CHIP :
                         (opc == `SFSPI_OP_OTP_PROG) ? OPK_OTP_PROG : OPK_PROG;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_m <= `SFSPI_PIN_IDLE;
      pin_s <= `SFSPI_PIN_IDLE;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else if (ce) begin
      pin_m <= {link.cs_n, link.sck, link.hold_n, link.wp_n,
                link.serial_in_dual_line, link.serial_out_dual_line};
      pin_s <= pin_m;
      sck_q <= sck_s;
      cs_q <= cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= DS_IDLE;
      opc <= 8'h00;
      sh <= 8'h00;
      bitcnt <= 3'h0;
      acnt <= 2'h0;
      addr <= 24'h000000;
      wr_cnt <= 9'h000;
      rd_on <= 1'b0;
    end else if (ce) begin
      if (frame_start) begin
        // new operation only on select fall
        st <= DS_CMD;
        bitcnt <= 3'h0;
        acnt <= 2'h0;
        wr_cnt <= 9'h000;
        rd_on <= 1'b0;
      end else if (cs_n_s) begin
        st <= DS_IDLE;
      end else if (rise) begin
        bitcnt <= next_bit;
        if (st != DS_RDATA) sh <= next_sh;
        if (byte_done) begin
          case (st)
            DS_CMD: begin
              opc <= next_sh;
              st <= sfspi_has_addr(next_sh) ? DS_ADDR :
                    (next_sh == `SFSPI_OP_STATUS) ? DS_RDATA :
                    no_addr ? DS_ARMED : DS_SKIP;
            end
            DS_ADDR: begin
              addr <= {addr[15:0], next_sh};
              acnt <= acnt + 2'h1;
              if (acnt == 2'h2) st <= is_read ? DS_RDATA : (is_prog ? DS_WDATA : DS_ARMED);
            end
            DS_WDATA: if (wr_take) wr_cnt <= wr_cnt + 9'h001;
            default: st <= st;
          endcase
        end
      end else if (fall & (st == DS_RDATA)) begin
        rd_on <= 1'b1;
        sh <= two ? {out_byte[5:0], 2'h0} : {out_byte[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-sector protection and lock bits
  for (genvar i = 0; i < `SFSPI_SECTORS; i++) begin : g_sector
    wire hit = sector == i[3:0];
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        prot[i] <= 1'b0;
        lock[i] <= 1'b0;
      end else if (ce) begin
        if (set_all | (set_one & hit)) prot[i] <= 1'b1;
        else if (clr_all | (clr_one & hit)) prot[i] <= 1'b0;
        if (go & hit & (opc == `SFSPI_OP_LOCK)) lock[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fail <= 1'b0;
      otp_used <= 1'b0;
      mem_start <= 1'b0;
      mem_op <= OPK_NONE;
      mem_addr <= 24'h000000;
      mem_len <= 9'h000;
      mem_wdata <= 8'h00;
      mem_wvalid <= 1'b0;
      rd_addr <= 24'h000000;
      rd_otp <= 1'b0;
      standby <= 1'b1;
      wp_lock <= 1'b0;
    end else if (ce) begin
      // refusal or back-end failure sets, set wins
      fail <= refuse | mem_fail | (fail & ~launch);
      if (launch & (opc == `SFSPI_OP_OTP_PROG)) otp_used <= 1'b1;
      mem_start <= launch;
      if (launch) begin
        mem_op <= kind;
        mem_addr <= addr;
        mem_len <= wr_cnt;
      end
      mem_wvalid <= wr_take;
      if (wr_take) mem_wdata <= next_sh;
      if (byte_done & (st == DS_ADDR) & (acnt == 2'h2)) rd_addr <= {addr[15:0], next_sh};
      else if (byte_done & (st == DS_RDATA)) rd_addr <= rd_addr + 24'h000001;
      rd_otp <= opc == `SFSPI_OP_OTP_READ;
      standby <= cs_n_s & ~mem_busy;
      wp_lock <= ~wp_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link.dev_soi_o <= 1'b1;
      link.dev_sio_o <= 1'b1;
      link.dev_soi_oe <= 1'b0;
      link.dev_sio_oe <= 1'b0;
    end else if (ce) begin
      // new bits only on clock fall
      if (fall & (st == DS_RDATA)) begin
        link.dev_soi_o <= out_byte[7];
        link.dev_sio_o <= out_byte[6];
      end
      link.dev_soi_oe <= active & (st == DS_RDATA) & (rd_on | fall);
      link.dev_sio_oe <= active & (st == DS_RDATA) & (rd_on | fall) & dual_rd;
    end
  end
endmodule : sfspi_dev_end

// file: verif/sfspi_link_monitor.sv
// checker on the link pins between the two ends
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/1ps
module sfspi_link_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic host_sio_oe,
  input wire logic host_soi_oe,
  input wire logic dev_sio_oe,
  input wire logic dev_soi_oe,
  input wire logic dev_soi_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // oe drops within 4 cycles, so 5 is safe
  desel_float_a: assert property (cs_n [*5] |-> !dev_soi_oe && !dev_sio_oe)
    else $error("output driven while deselected");
  hold_float_a: assert property ((!hold_n) [*5] |-> !dev_soi_oe && !dev_sio_oe)
    else $error("output driven during hold");
  fall_change_a: assert property (dev_soi_oe && $changed(dev_soi_o) |-> !sck)
    else $error("output changed while clock high");
  dual_pair_a: assert property (dev_sio_oe |-> dev_soi_oe)
    else $error("second line driven alone");
  no_fight_a: assert property (!(dev_soi_oe && host_soi_oe) && !(dev_sio_oe && host_sio_oe))
    else $error("both ends drive a data line");
  sel_edge_a: assert property ($fell(cs_n) |-> !sck && $past(sck) == 1'b0)
    else $error("select fell with clock high");
  idle_clk_a: assert property (cs_n |-> !sck)
    else $error("clock not idle low");
  hold_start_a: assert property ($fell(hold_n) |-> !cs_n && !sck)
    else $error("hold began outside a low clock");
  hold_clk_a: assert property (!hold_n |-> $stable(sck))
    else $error("clock moved during hold");
  drive_sel_a: assert property ($rose(dev_soi_oe) |-> !cs_n && hold_n)
    else $error("output enabled while idle");
endmodule : sfspi_link_monitor

// file: verif/serial_flash_spi_front_end_tb_top.sv
// bench: host end and device end joined by the link, user-side tasks
// assumes sfspi_pkg and the link interface compiled first
`timescale 1ns/1ps
`include "sfspi_params.svh"
module serial_flash_spi_front_end_tb_top
  import sfspi_pkg::*;
;
  logic        clk_sys, sys_rst, start, addr_en, dual_en, hold_req, wp_req, busy, wr_take, rd_valid;
  logic        mem_start, mem_wvalid, rd_otp, standby, wp_lock, mem_busy, mem_fail, fi;
  logic [7:0]  cmd_op, h_rd, b_rd, wi, wr_data, mem_wdata;
  logic [23:0] cmd_addr, rd_addr, mem_addr, sad;
  logic [8:0]  wr_len, rd_len, mem_len, sln;
  logic [2:0]  bc;
  sfspi_op_e   mem_op, sop;
  int          sc, miscompares, checks_done;
  logic [7:0]  rq[$], wq[$];
  sfspi_op_e   ers[4] = '{OPK_ERASE4K, OPK_ERASE32K, OPK_ERASE64K, OPK_CHIP};
  sfspi_link_if lk ();
  sfspi_host_end u_sfspi_host_end (.clk_sys, .sys_rst, .ce(1'b1), .start, .cmd_op, .cmd_addr, .addr_en,
    .wr_len, .rd_len, .dual_en, .wr_data, .hold_req, .wp_req, .busy, .wr_take, .rd_data(h_rd), .rd_valid,
    .link(lk.host));
  sfspi_dev_end u_sfspi_dev_end (.clk_sys, .sys_rst, .ce(1'b1), .rd_data(b_rd), .mem_busy, .mem_fail,
    .mem_start, .mem_op, .mem_addr, .mem_len, .mem_wdata, .mem_wvalid, .rd_addr, .rd_otp, .standby,
    .wp_lock, .link(lk.dev));
  sfspi_link_monitor u_sfspi_link_monitor (.clk_sys, .sys_rst, .cs_n(lk.cs_n), .sck(lk.sck),
    .hold_n(lk.hold_n), .host_sio_oe(lk.host_sio_oe), .host_soi_oe(lk.host_soi_oe),
    .dev_sio_oe(lk.dev_sio_oe), .dev_soi_oe(lk.dev_soi_oe), .dev_soi_o(lk.dev_soi_o));
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  assign wr_data  = 8'h30 + wi;
  // short busy so the next frame is never dropped
  assign mem_busy = (bc != 3'h0);
  // injected back-end failure, late in the busy span
  assign mem_fail = fi & (bc == 3'h1);
  always @(negedge clk_sys) if (bc == 3'h2) chk({23'h0, standby}, 24'h0);
  always @(posedge clk_sys) begin
    if (start) wi <= 8'h00;
    else if (wr_take) wi <= wi + 8'h01;
    if (rd_valid) rq.push_back(h_rd);
    if (mem_wvalid) wq.push_back(mem_wdata);
    if (mem_start) begin
      sc  <= sc + 1;
      sop <= mem_op;
      sad <= mem_addr;
      sln <= mem_len;
    end
    b_rd <= rd_addr[7:0] ^ 8'ha5;
    if (sys_rst) bc <= 3'h0;
    else if (mem_start) bc <= 3'h4;
    else if (bc != 3'h0) bc <= bc - 3'h1;
  end
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic ae, input logic dl,
                     input logic [8:0] wl, input logic [8:0] rl);
    int n;
    rq.delete();
    wq.delete();
    sc = 0;
    cmd_op = op;
    cmd_addr = a;
    addr_en = ae;
    dual_en = dl;
    wr_len = wl;
    rd_len = rl;
    start = 1'b1;
    @(posedge clk_sys);
    #1 start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40000) begin
      miscompares++;
      results();
    end
    repeat (16) @(posedge clk_sys);
    #1;
  endtask : run
  task automatic rdq(input logic [23:0] a, input int n);
    chk(24'(rq.size()), 24'(n));
    foreach (rq[k]) chk({16'h0, rq[k]}, {16'h0, (a[7:0] + 8'(k)) ^ 8'ha5});
  endtask : rdq
  task automatic pgq(input sfspi_op_e op, input logic [23:0] a, input logic ca, input int n);
    chk(24'(sc), 24'h1);
    chk({20'h0, sop}, {20'h0, op});
    if (ca) chk(sad, a);
    chk({15'h0, sln}, 24'(n));
    foreach (wq[k]) chk({16'h0, wq[k]}, {16'h0, 8'h30 + 8'(k)});
  endtask : pgq
  task automatic st(input logic [7:0] e);
    run(`SFSPI_OP_STATUS, 24'h0, 1'b0, 1'b0, 9'h0, 9'h1);
    chk(24'(rq.size()), 24'h1);
    chk({16'h0, rq[0]}, {16'h0, e});
  endtask : st
  ////////////////////////////////////////
  initial begin
    #2000000;
    miscompares++;
    results();
  end
  initial begin
    {sys_rst, start, addr_en, dual_en, hold_req, wp_req} = 6'h20;
    {cmd_op, cmd_addr, wr_len, rd_len, wi, fi} = '0;
    {sc, miscompares, checks_done} = '0;
    repeat (6) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk({23'h0, standby}, 24'h1);
    run(`SFSPI_OP_READ, 24'h012340, 1'b1, 1'b0, 9'h0, 9'h3);
    rdq(24'h012340, 3);
    run(`SFSPI_OP_DREAD, 24'h0123fe, 1'b1, 1'b1, 9'h0, 9'h4);
    rdq(24'h0123fe, 4);
    run(`SFSPI_OP_PROG, 24'h020010, 1'b1, 1'b0, 9'h3, 9'h0);
    pgq(OPK_PROG, 24'h020010, 1'b1, 3);
    run(`SFSPI_OP_DPROG, 24'h020100, 1'b1, 1'b1, 9'h2, 9'h0);
    pgq(OPK_PROG, 24'h020100, 1'b1, 2);
    // one byte past a page, the extra one is dropped
    run(`SFSPI_OP_PROG, 24'h020000, 1'b1, 1'b0, 9'h101, 9'h0);
    pgq(OPK_PROG, 24'h020000, 1'b1, 256);
    for (int i = 0; i < 4; i++) begin
      run(`SFSPI_OP_ERASE4K + 8'(i), 24'h010000, i < 3, 1'b0, 9'h0, 9'h0);
      pgq(ers[i], 24'h010000, i < 3, 0);
    end
    run(`SFSPI_OP_PROTECT, 24'h030000, 1'b1, 1'b0, 9'h0, 9'h0);
    run(`SFSPI_OP_PROG, 24'h030004, 1'b1, 1'b0, 9'h1, 9'h0);
    chk(24'(sc), 24'h0);
    st(8'h02);
    run(`SFSPI_OP_PROG, 24'h020200, 1'b1, 1'b0, 9'h1, 9'h0);
    st(8'h00);
    fi = 1'b1;
    run(`SFSPI_OP_PROG, 24'h020300, 1'b1, 1'b0, 9'h1, 9'h0);
    fi = 1'b0;
    st(8'h02);
    wp_req = 1'b1;
    run(`SFSPI_OP_UNPROTECT, 24'h030000, 1'b1, 1'b0, 9'h0, 9'h0);
    chk({23'h0, wp_lock}, 24'h1);
    st(8'h02);
    wp_req = 1'b0;
    run(`SFSPI_OP_UNPROTECT, 24'h030000, 1'b1, 1'b0, 9'h0, 9'h0);
    run(`SFSPI_OP_PROG, 24'h030004, 1'b1, 1'b0, 9'h1, 9'h0);
    chk(24'(sc), 24'h1);
    run(`SFSPI_OP_LOCK, 24'h050000, 1'b1, 1'b0, 9'h0, 9'h0);
    run(`SFSPI_OP_GUNPROT, 24'h0, 1'b0, 1'b0, 9'h0, 9'h0);
    run(`SFSPI_OP_PROG, 24'h050000, 1'b1, 1'b0, 9'h1, 9'h0);
    chk(24'(sc), 24'h0);
    run(`SFSPI_OP_GPROTECT, 24'h0, 1'b0, 1'b0, 9'h0, 9'h0);
    run(`SFSPI_OP_PROG, 24'h020400, 1'b1, 1'b0, 9'h1, 9'h0);
    chk(24'(sc), 24'h0);
    run(`SFSPI_OP_OTP_PROG, 24'h000010, 1'b1, 1'b0, 9'h1, 9'h0);
    pgq(OPK_OTP_PROG, 24'h000010, 1'b1, 1);
    run(`SFSPI_OP_OTP_PROG, 24'h000020, 1'b1, 1'b0, 9'h1, 9'h0);
    chk(24'(sc), 24'h0);
    run(`SFSPI_OP_OTP_READ, 24'h000004, 1'b1, 1'b0, 9'h0, 9'h2);
    rdq(24'h000004, 2);
    chk({23'h0, rd_otp}, 24'h1);
    fork
      run(`SFSPI_OP_READ, 24'h0456a0, 1'b1, 1'b0, 9'h0, 9'h3);
      begin
        repeat (600) @(posedge clk_sys);
        #1 hold_req = 1'b1;
        repeat (60) @(posedge clk_sys);
        #1 hold_req = 1'b0;
      end
    join
    rdq(24'h0456a0, 3);
    results();
  end
endmodule : serial_flash_spi_front_end_tb_top
